// ### dmabi_pkg.sv
// Purpose: Shared constants and types for the DMA bus interface signalling block
// Assumes: One 200 MHz clock, all pins sampled synchronously
// Notes:   Channel 4 is the internal cascade and has no request pin
package dmabi_pkg;
  localparam int          CHAN_W          = 3;
  localparam int          NUM_CHAN        = 8;
  localparam int          LO_ADDR_W       = 10;
  localparam int          HI_ADDR_W       = 14;
  localparam int          CNT_W           = 16;
  localparam int          REFRESH_STROBE_N_W          = 9;
  localparam int          PAGE_W          = 8;
  localparam int          PAGE_POS        = 6;
  localparam logic [2:0]  CASCADE_CHAN    = 3'h4;
  localparam logic [15:0] WCNT_RESET      = 16'h0003;
  localparam logic [15:0] ACNT_RESET      = 16'h0000;
  localparam logic [7:0]  PAGE_RESET      = 8'h00;
  localparam logic [7:0]  REFRESH_STROBE_N_PAGE_RESET = 8'h00;
  localparam logic [8:0]  REFRESH_STROBE_N_CNT_RESET  = 9'h000;

  typedef enum logic [4:0] {
    DMABI_IDLE = 5'b00001,
    DMABI_REQ  = 5'b00010,
    DMABI_ADDR = 5'b00100,
    DMABI_WAIT = 5'b01000,
    DMABI_DONE = 5'b10000
  } dmabi_state_t;

  typedef struct packed {
    dmabi_state_t                          st;
    logic [CHAN_W-1:0]                     chan;
    logic                                  bus_req;
    logic                                  dma_cycle_flag;
    logic                                  ack_decode_enable_n_n;
    logic                                  tc;
    logic                                  system_latch_strobe;
    logic [HI_ADDR_W-1:0]                  hi_addr;
    logic [LO_ADDR_W-1:0]                  lo_addr;
    logic                                  lo_oe;
    logic [LO_ADDR_W-1:0]                  lat_addr;
    logic                                  refresh_strobe_n_n_prev;
    logic [REFRESH_STROBE_N_W-1:0]                     refresh_strobe_n_cnt;
    logic [NUM_CHAN-1:0][CNT_W-1:0]        wcnt;
    logic [NUM_CHAN-1:0][CNT_W-1:0]        acnt;
  } dmabi_regs_t;
endpackage

// ### dmabi_top.sv
// Purpose: Bus request/grant, encoded acknowledge, end-of-operation, DMA-cycle
//          flag, system latch strobe, CPU address capture and refresh address
// Assumes: Pins synchronous to core_clk_in; async reset_in, sync clear_n_in
// Notes:   One transfer per grant, bus released between transfers
//          A new DMA request is held off while the refresh strobe is low
`timescale 1ns/1ps
module dmabi_top
  import dmabi_pkg::*;
#(
  parameter logic [7:0]  PAGE       = dmabi_pkg::PAGE_RESET,
  parameter logic [7:0]  REFRESH_STROBE_N_PAGE  = dmabi_pkg::REFRESH_STROBE_N_PAGE_RESET,
  parameter logic [15:0] WCNT_INIT  = dmabi_pkg::WCNT_RESET
) (
  input  wire logic                              core_clk_in,
  input  wire logic                              reset_in,
  input  wire logic                              clear_n_in,
  input  wire logic                              channel0_request_in,
  input  wire logic                              channel1_request_in,
  input  wire logic                              channel2_request_in,
  input  wire logic                              channel3_request_in,
  input  wire logic                              channel5_request_in,
  input  wire logic                              channel6_request_in,
  input  wire logic                              channel7_request_in,
  input  wire logic                              bus_grant_in,
  input  wire logic                              transfer_ready_in,
  input  wire logic                              refresh_strobe_n_in,
  input  wire logic                              addr_latch_en_in,
  input  wire logic [dmabi_pkg::LO_ADDR_W-1:0]   lower_address_bus_in,
  output logic      [dmabi_pkg::LO_ADDR_W-1:0]   lower_address_bus_out,
  output logic                                   lower_address_bus_oe_out,
  output logic      [dmabi_pkg::HI_ADDR_W-1:0]   upper_address_out,
  output logic      [dmabi_pkg::LO_ADDR_W-1:0]   cpu_address_out,
  output logic                                   bus_request_out,
  output logic                                   ack_code_bit0_out,
  output logic                                   ack_code_bit1_out,
  output logic                                   ack_code_bit2_out,
  output logic                                   ack_decode_enable_n_out,
  output logic                                   terminal_count_out,
  output logic                                   dma_cycle_flag_out,
  output logic                                   system_latch_strobe_out
);
  import dmabi_pkg::*;

  dmabi_regs_t r_q;
  dmabi_regs_t r_d;
  logic [NUM_CHAN-1:0] req_vec;
  logic [CHAN_W:0]     pick;
  logic                refresh_strobe_n_rise;

  // Controller for channels 5-7 wins over 0-3; lowest number first within each
  function automatic logic [CHAN_W:0] arbitrate(input logic [NUM_CHAN-1:0] rq);
    logic [CHAN_W:0] res;
    res = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (rq[(i + 5) % NUM_CHAN] && ((i + 5) % NUM_CHAN) != int'(CASCADE_CHAN)) begin
        res = {1'b1, CHAN_W'((i + 5) % NUM_CHAN)};
      end
    end
    return res;
  endfunction

  function automatic logic [HI_ADDR_W-1:0] upper_of(input logic [7:0] page,
                                                   input logic [CNT_W-1:0] addr);
    return {page, addr[CNT_W-1:LO_ADDR_W]};
  endfunction

  // Word count at zero means this transfer is the last of the block
  function automatic logic count_expired(input logic [CNT_W-1:0] wc);
    return wc == '0;
  endfunction

  // Reload on expiry so the channel is ready for another block
  function automatic logic [CNT_W-1:0] count_next(input logic [CNT_W-1:0] wc);
    return count_expired(wc) ? WCNT_INIT : wc - CNT_W'(1);
  endfunction

  // During refresh only the page bits above the row counter are meaningful
  function automatic logic [HI_ADDR_W-1:0] refresh_upper(input logic [7:0] page);
    return {page, PAGE_POS'(0)};
  endfunction

  // Channel 4 has no pin and stays low
  assign req_vec = {channel7_request_in, channel6_request_in, channel5_request_in, 1'b0,
                    channel3_request_in, channel2_request_in, channel1_request_in, channel0_request_in};
  assign pick    = arbitrate(req_vec);

  // Counter advances as a refresh cycle ends, so the next one sees a new row
  assign refresh_strobe_n_rise = refresh_strobe_n_in && !r_q.refresh_strobe_n_n_prev;

  always_comb begin
    r_d             = r_q;
    r_d.system_latch_strobe      = 1'b0;
    r_d.tc          = 1'b0;
    r_d.refresh_strobe_n_n_prev = refresh_strobe_n_in;
    // Bits above 0 captured on the strobe, bit 0 follows the pin
    if (addr_latch_en_in) begin
      r_d.lat_addr[LO_ADDR_W-1:1] = lower_address_bus_in[LO_ADDR_W-1:1];
    end
    r_d.lat_addr[0] = lower_address_bus_in[0];
    // Refresh counter steps on the rising edge of the strobe
    if (refresh_strobe_n_rise) begin
      r_d.refresh_strobe_n_cnt = r_q.refresh_strobe_n_cnt + REFRESH_STROBE_N_W'(1);
    end
    case (r_q.st)
      DMABI_IDLE: begin
        r_d.lo_oe = !refresh_strobe_n_in;
        r_d.lo_addr = {1'b0, r_d.refresh_strobe_n_cnt};
        r_d.hi_addr = refresh_upper(REFRESH_STROBE_N_PAGE);
        if (pick[CHAN_W] && refresh_strobe_n_in) begin
          r_d.bus_req = 1'b1;
          r_d.chan    = pick[CHAN_W-1:0];
          r_d.st      = DMABI_REQ;
        end
      end
      DMABI_REQ: begin
        if (bus_grant_in) begin
          r_d.st       = DMABI_ADDR;
          r_d.dma_cycle_flag      = 1'b1;
          r_d.ack_decode_enable_n_n = 1'b0;
          r_d.system_latch_strobe   = 1'b1;
          r_d.lo_oe    = 1'b1;
          r_d.lo_addr  = r_q.acnt[r_q.chan][LO_ADDR_W-1:0];
          r_d.hi_addr  = upper_of(PAGE, r_q.acnt[r_q.chan]);
        end else if (!pick[CHAN_W]) begin
          r_d.bus_req = 1'b0;
          r_d.st      = DMABI_IDLE;
        end else begin
          // Priority is re-evaluated every cycle until the grant
          r_d.chan = pick[CHAN_W-1:0];
        end
      end
      DMABI_ADDR: begin
        r_d.st = DMABI_WAIT;
      end
      DMABI_WAIT: begin
        if (transfer_ready_in) begin
          r_d.st               = DMABI_DONE;
          r_d.tc               = count_expired(r_q.wcnt[r_q.chan]);
          r_d.wcnt[r_q.chan]   = count_next(r_q.wcnt[r_q.chan]);
          r_d.acnt[r_q.chan]   = r_q.acnt[r_q.chan] + CNT_W'(1);
        end
      end
      DMABI_DONE: begin
        // Bus goes back to the host after every transfer
        r_d.st       = DMABI_IDLE;
        r_d.dma_cycle_flag      = 1'b0;
        r_d.ack_decode_enable_n_n = 1'b1;
        r_d.bus_req  = 1'b0;
        r_d.lo_oe    = 1'b0;
      end
      default: begin
        r_d.st = DMABI_IDLE;
      end
    endcase
    if (!clear_n_in) begin
      r_d.st       = DMABI_IDLE;
      r_d.bus_req  = 1'b0;
      r_d.tc       = 1'b0;
      r_d.dma_cycle_flag      = 1'b0;
      r_d.ack_decode_enable_n_n = 1'b1;
      r_d.system_latch_strobe   = 1'b0;
      r_d.lo_oe    = 1'b0;
      r_d.chan     = '0;
      r_d.refresh_strobe_n_cnt = REFRESH_STROBE_N_CNT_RESET;
      for (int c = 0; c < NUM_CHAN; c++) begin
        r_d.wcnt[c] = WCNT_INIT;
        r_d.acnt[c] = ACNT_RESET;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r_q.st          <= DMABI_IDLE;
      r_q.chan        <= '0;
      r_q.bus_req     <= 1'b0;
      r_q.dma_cycle_flag         <= 1'b0;
      r_q.ack_decode_enable_n_n    <= 1'b1;
      r_q.tc          <= 1'b0;
      r_q.system_latch_strobe      <= 1'b0;
      r_q.hi_addr     <= '0;
      r_q.lo_addr     <= '0;
      r_q.lo_oe       <= 1'b0;
      r_q.lat_addr    <= '0;
      r_q.refresh_strobe_n_n_prev <= 1'b1;
      r_q.refresh_strobe_n_cnt    <= REFRESH_STROBE_N_CNT_RESET;
      for (int c = 0; c < NUM_CHAN; c++) begin
        r_q.wcnt[c] <= WCNT_INIT;
        r_q.acnt[c] <= ACNT_RESET;
      end
    end else begin
      r_q <= r_d;
    end
  end

  // The channel register never holds 4, since arbitration skips it
  assign ack_code_bit0_out        = r_q.chan[0];
  assign ack_code_bit1_out        = r_q.chan[1];
  assign ack_code_bit2_out        = r_q.chan[2];
  assign ack_decode_enable_n_out  = r_q.ack_decode_enable_n_n;
  assign bus_request_out          = r_q.bus_req;
  assign terminal_count_out       = r_q.tc;
  assign dma_cycle_flag_out       = r_q.dma_cycle_flag;
  assign system_latch_strobe_out  = r_q.system_latch_strobe;
  assign lower_address_bus_out    = r_q.lo_addr;
  assign lower_address_bus_oe_out = r_q.lo_oe;
  assign upper_address_out        = r_q.hi_addr;
  assign cpu_address_out          = r_q.lat_addr;
endmodule

// ### dmabi_props.sv
// Purpose: Port-level checks for the DMA bus interface block
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module dmabi_props (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clear_n_in,
  input wire logic bus_grant_in,
  input wire logic transfer_ready_in,
  input wire logic bus_request_out,
  input wire logic ack_code_bit0_out,
  input wire logic ack_code_bit1_out,
  input wire logic ack_code_bit2_out,
  input wire logic ack_decode_enable_n_out,
  input wire logic terminal_count_out,
  input wire logic dma_cycle_flag_out,
  input wire logic system_latch_strobe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  ack_code_legal_a: assert property (
    !ack_decode_enable_n_out |-> {ack_code_bit2_out, ack_code_bit1_out, ack_code_bit0_out} != 3'h4)
    else $error("illegal acknowledge code driven");
  enable_in_cycle_a: assert property (!ack_decode_enable_n_out |-> dma_cycle_flag_out)
    else $error("decode enable low outside a DMA cycle");
  strobe_start_a: assert property ($rose(dma_cycle_flag_out) |-> system_latch_strobe_out)
    else $error("no latch strobe at cycle start");
  strobe_pulse_a: assert property (system_latch_strobe_out |=> !system_latch_strobe_out)
    else $error("latch strobe longer than one cycle");
  tc_pulse_a: assert property (terminal_count_out |=> !terminal_count_out && !dma_cycle_flag_out)
    else $error("terminal count not a closing pulse");
  grant_start_a: assert property (
    $rose(dma_cycle_flag_out) |-> $past(bus_request_out) && $past(bus_grant_in))
    else $error("DMA cycle began without request and grant");
  ready_hold_a: assert property (
    dma_cycle_flag_out && !system_latch_strobe_out && !transfer_ready_in && !$past(transfer_ready_in)
      && clear_n_in |=> dma_cycle_flag_out)
    else $error("cycle ended without transfer ready");
  clear_idle_a: assert property (!clear_n_in |=> !bus_request_out && !terminal_count_out &&
    !dma_cycle_flag_out && ack_decode_enable_n_out)
    else $error("outputs not idle after system clear");
endmodule
bind dmabi_top dmabi_props u_dmabi_props (.*);

// ### dmabi_host_model.sv
// Purpose: Host side, grants the bus and paces transfer ready
// Assumes: Grant follows the bus request one cycle later
// Notes:   delay_in sets the DMA cycles that pass before ready
`timescale 1ns/1ps
module dmabi_host_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       bus_request_in,
  input  wire logic       dma_cycle_flag_in,
  input  wire logic [3:0] delay_in,
  output logic            bus_grant_out,
  output logic            transfer_ready_out
);
  logic [3:0] wait_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_grant_out      <= 1'b0;
      transfer_ready_out <= 1'b0;
      wait_q             <= 4'h0;
    end else begin
      bus_grant_out      <= bus_request_in;
      wait_q             <= dma_cycle_flag_in ? wait_q + 4'h1 : 4'h0;
      transfer_ready_out <= dma_cycle_flag_in && (wait_q >= delay_in);
    end
  end
endmodule

// ### test_dmabi_top.sv
// Purpose: Self-checking bench for the DMA bus interface block
// Assumes: Word count reload of 3, so each 4th transfer ends the count
// Notes:   Ready delay, latch enable and CPU address are random
`timescale 1ns/1ps
module test_dmabi_top;
  logic       clk = 1'b0, rst = 1'b1, clr_n = 1'b1, ale = 1'b0, refresh_strobe_n_n = 1'b1;
  logic [7:0] req = 8'h00;
  logic [9:0] a_in = 10'h000, lo_out, cpu_out, cpu_exp = 10'h000;
  logic [13:0] up_out;
  logic [3:0] dly = 4'h0;
  logic       grant, ready, breq, a0, a1, a2, en_n, tc, flag, stb, oe;
  int         n_errors = 0, samples_checked = 0, cycles = 0, seed = 50551;
  int         chans[7] = '{0, 1, 2, 3, 5, 6, 7};
  int         addr_exp[8];
  always #2.5 clk = ~clk;
  dmabi_top u_dmabi_top (.core_clk_in(clk), .reset_in(rst), .clear_n_in(clr_n),
    .channel0_request_in(req[0]), .channel1_request_in(req[1]), .channel2_request_in(req[2]),
    .channel3_request_in(req[3]), .channel5_request_in(req[5]), .channel6_request_in(req[6]),
    .channel7_request_in(req[7]), .bus_grant_in(grant), .transfer_ready_in(ready),
    .refresh_strobe_n_in(refresh_strobe_n_n), .addr_latch_en_in(ale), .lower_address_bus_in(a_in),
    .lower_address_bus_out(lo_out), .lower_address_bus_oe_out(oe), .upper_address_out(up_out),
    .cpu_address_out(cpu_out), .bus_request_out(breq), .ack_code_bit0_out(a0), .ack_code_bit1_out(a1),
    .ack_code_bit2_out(a2), .ack_decode_enable_n_out(en_n), .terminal_count_out(tc),
    .dma_cycle_flag_out(flag), .system_latch_strobe_out(stb));
  dmabi_host_model u_dmabi_host_model (.clk_in(clk), .reset_in(rst), .bus_request_in(breq),
    .dma_cycle_flag_in(flag), .delay_in(dly), .bus_grant_out(grant), .transfer_ready_out(ready));
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Fixed priority 5,6,7,0,1,2,3; the last hit walking downward wins
  function automatic logic [2:0] exp_chan(input logic [7:0] r);
    exp_chan = 3'h0;
    for (int k = 6; k >= 0; k--) begin
      if (r[chans[(k + 4) % 7]]) exp_chan = 3'(chans[(k + 4) % 7]);
    end
  endfunction
  // Bits 9..1 follow the pins only while the strobe is high, bit 0 always
  function automatic logic [9:0] latch_next(input logic [9:0] held, input logic en, input logic [9:0] a);
    latch_next = {en ? a[9:1] : held[9:1], a[0]};
  endfunction
  always @(posedge clk) if (!rst) cpu_exp <= latch_next(cpu_exp, ale, a_in);
  always @(negedge clk) if (!rst) check(16'(cpu_out), 16'(cpu_exp));
  task automatic xfer(input logic [7:0] r, input logic exp_tc);
    logic       seen_tc;
    logic [2:0] c;
    seen_tc = 1'b0;
    c = exp_chan(r);
    req = r;
    while (flag !== 1'b1) @(negedge clk);
    check({a2, a1, a0}, c);
    check({stb, en_n, breq}, 3'b101);
    check({oe, lo_out}, {1'b1, 10'(addr_exp[c])});
    check(up_out, {dmabi_pkg::PAGE_RESET, 6'(addr_exp[c] >> 10)});
    req = 8'h00;
    while (flag === 1'b1) begin
      seen_tc |= (tc === 1'b1);
      @(negedge clk);
    end
    addr_exp[c]++;
    check({seen_tc, breq, en_n}, {exp_tc, 2'b01});
  endtask
  always @(negedge clk) begin
    ale  <= 1'($random(seed));
    a_in <= 10'($random(seed));
    dly  <= 4'($random(seed)) & 4'h7;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    for (int p = 0; p < 4; p++) foreach (chans[i]) xfer(8'h01 << chans[i], p == 3);
    xfer(8'hEF, 1'b0);
    req = 8'h01;
    while (flag !== 1'b1) @(negedge clk);
    clr_n = 1'b0;
    @(negedge clk);
    check({breq, tc, flag, en_n}, 4'b0001);
    foreach (addr_exp[i]) addr_exp[i] = 0;
    clr_n = 1'b1;
    req = 8'h00;
    repeat (3) @(negedge clk);
    for (int p = 0; p < 4; p++) xfer(8'h01, p == 3);
    for (int r = 0; r < 3; r++) begin
      refresh_strobe_n_n = 1'b0;
      repeat (3) @(negedge clk);
      check({oe, lo_out}, {1'b1, 10'(r)});
      check(up_out, {dmabi_pkg::REFRESH_STROBE_N_PAGE_RESET, 6'h00});
      refresh_strobe_n_n = 1'b1;
      repeat (2) @(negedge clk);
    end
    give_verdict();
  end
endmodule
